// file: operand_addressing_decoder.sv
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
`include "oad_defines.svh"
module operand_addressing_decoder (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// =====================================================
	// Storage
	logic [7:0] gregs [0:31]; // Four banks of eight bytes
	logic [31:0] ctrl_r; // Operand command word
	logic [31:0] oper_r; // Operand value and flag actions
	logic [31:0] result_r; // Last decode result
	logic [7:0] psw_r; // Status word
	logic [7:0] savedPsw_r; // Copy for restore action
	logic [1:0] bank_r; // Bank in force for current instruction
	logic [15:0] gregRd_r; // Last register byte or pair read
	logic exec_r; // Execute pulse, one cycle after the control write lands
	logic awHeld_r, wHeld_r;
	logic [11:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	// =====================================================
	// Decode of held write address
	// Kept ahead of the write channel, which reads wrMapped
	wire logic wrCtrl = (awAddr_r == `OAD_OFF_CTRL);
	wire logic wrOper = (awAddr_r == `OAD_OFF_OPER);
	wire logic wrPsw = (awAddr_r == `OAD_OFF_PSW);
	wire logic wrGreg = (awAddr_r == `OAD_OFF_GREG);
	wire logic wrMapped = wrCtrl | wrOper | wrPsw | wrGreg |
		(awAddr_r == `OAD_OFF_STAT) | (awAddr_r == `OAD_OFF_RESULT);
	// =====================================================
	// Write channel: take address and data in either order
	wire logic wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
	wire logic awTake = s_axi_awvalid && s_axi_awready;
	wire logic wTake = s_axi_wvalid && s_axi_wready;
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 12'h000;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end
		else
		begin
			s_axi_awready <= !awHeld_r && !awTake;
			s_axi_wready <= !wHeld_r && !wTake;
			if (awTake)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (wTake)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (wrFire)
			begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrMapped ? 2'b00 : 2'b10;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	// Byte-lane merge
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = n[i*8 +: 8];
		return r;
	endfunction : merge
	// =====================================================
	// Control fields: [3:0] mode, [4] sfr16 capable, [5] execute,
	// [8:6] reg index, [9] pair access; bit pos sits in operand [2:0]
	// and flag actions IE..CY 3 bits each in operand [27:16]
	wire logic [31:0] ctrlNew = merge(ctrl_r, wData_r, wStrb_r);
	wire logic execGo = wrFire && wrCtrl && ctrlNew[5];
	// Status word after a bus write, byte lanes honoured
	wire logic [31:0] pswWr = merge({24'h00_0000, psw_r}, wData_r, wStrb_r);
	// Flag actions live in the operand register upper half
	wire logic [2:0] actCy = oper_r[18:16];
	wire logic [2:0] actAc = oper_r[21:19];
	wire logic [2:0] actZ = oper_r[24:22];
	wire logic [2:0] actIe = oper_r[27:25];
	wire logic [2:0] immBit = oper_r[2:0];
	wire logic [7:0] immByte = oper_r[7:0];
	wire logic [15:0] immWord = oper_r[15:0];
	// =====================================================
	// Register index mapping
	// X,A,C,B,E,D,L,H order
	wire logic [2:0] regIdx = ctrl_r[8:6];
	// bank from flag
	// The executing access already uses the flag; bus writes use the bank in force
	wire logic [1:0] bankUse = exec_r ? {psw_r[`OAD_BANK_HI], psw_r[`OAD_BANK_LO]} : bank_r;
	wire logic [4:0] byteSel = {bankUse, regIdx};
	wire logic [4:0] pairLo = {bankUse, regIdx[1:0], 1'b0};
	wire logic [4:0] pairHi = {bankUse, regIdx[1:0], 1'b1};
	wire logic [15:0] pairVal = {gregs[pairHi], gregs[pairLo]};
	// Byte accumulator sits at index one of the bank
	wire logic [7:0] accVal = gregs[{bankUse, 3'd1}];
	wire logic [15:0] wordAcc = {gregs[{bankUse, 3'd1}], gregs[{bankUse, 3'd0}]};
	// =====================================================
	// Address resolution
	oad_pkg::oad_addr_s addrRes;
	oad_addr_check u_addr (
		.mode(ctrl_r[3:0]),
		.opnd(immWord),
		.pc(pairVal),
		.sfr16Ok(ctrl_r[4]),
		.res(addrRes)
	);
	// Result-dependent flags: Z and AC from the accumulator value, CY from the tested operand bit
	wire logic resZ = (accVal == 8'h00);
	wire logic resCy = immByte[immBit];
	wire logic resAc = accVal[3];
	wire logic [7:0] pswNxt;
	wire logic [2:0] acts [0:3];
	wire logic ress [0:3];
	wire logic [2:0] pos [0:3];
	assign acts[0] = actCy;
	assign acts[1] = actAc;
	assign acts[2] = actZ;
	assign acts[3] = actIe;
	assign ress[0] = resCy;
	assign ress[1] = resAc;
	assign ress[2] = resZ;
	assign ress[3] = 1'b0;
	assign pos[0] = 3'd`OAD_CY_BIT;
	assign pos[1] = 3'd`OAD_AC_BIT;
	assign pos[2] = 3'd`OAD_Z_BIT;
	assign pos[3] = 3'd`OAD_IE_BIT;
	logic [3:0] flagN;
	for (genvar g = 0; g < 4; g++)
	begin : g_flag
		oad_flag_unit u_flag (
			.act(acts[g]),
			.cur(psw_r[pos[g]]),
			.res(ress[g]),
			.saved(savedPsw_r[pos[g]]),
			.nxt(flagN[g])
		);
	end
	assign pswNxt = {flagN[3], flagN[2], psw_r[`OAD_BANK_HI], flagN[1],
		psw_r[`OAD_BANK_LO], psw_r[2:1], flagN[0]};
	// =====================================================
	// Execute: decode, flags, register access
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl_r <= 32'h0000_0000;
			oper_r <= 32'h0000_0000;
			result_r <= 32'h0000_0000;
			psw_r <= `OAD_PSW_RST;
			savedPsw_r <= `OAD_PSW_RST;
			bank_r <= 2'b00;
			gregRd_r <= 16'h0000;
			exec_r <= 1'b0;
		end
		else
		begin
			// Act one cycle after the control word lands, so decode sees it
			// No bus write can fire then, as the response is still pending
			exec_r <= execGo;
			if (wrFire && wrCtrl)
				ctrl_r <= {ctrlNew[31:6], 1'b0, ctrlNew[4:0]};
			if (wrFire && wrOper)
				oper_r <= merge(oper_r, wData_r, wStrb_r);
			if (wrFire && wrPsw)
			begin
				psw_r <= pswWr[7:0];
				savedPsw_r <= psw_r;
			end
			else if (exec_r)
			begin
				psw_r <= pswNxt;
				bank_r <= bankUse;
				result_r <= {7'h00, addrRes.legal, wordAcc[15:8], addrRes.addr};
				// Pair read returns both halves, byte read zero-extended
				gregRd_r <= ctrl_r[9] ? pairVal : {8'h00, gregs[byteSel]};
			end
		end
	end
	// Register file write, no reset needed for data
	always_ff @(posedge mclk)
	begin
		if (wrFire && wrGreg && wStrb_r[0])
			gregs[byteSel] <= wData_r[7:0];
	end
	// =====================================================
	// Read channel, one-cycle latency
	wire logic [31:0] rdMux =
		(s_axi_araddr == `OAD_OFF_CTRL) ? ctrl_r :
		(s_axi_araddr == `OAD_OFF_OPER) ? oper_r :
		(s_axi_araddr == `OAD_OFF_STAT) ? {22'h0, bank_r, psw_r} :
		(s_axi_araddr == `OAD_OFF_RESULT) ? result_r :
		(s_axi_araddr == `OAD_OFF_PSW) ? {24'h0, psw_r} :
		(s_axi_araddr == `OAD_OFF_GREG) ? {16'h0000, gregRd_r} : 32'h0000_0000;
	wire logic rdMapped = (s_axi_araddr <= `OAD_OFF_GREG) && (s_axi_araddr[1:0] == 2'b00);
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= rdMapped ? 2'b00 : 2'b10;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
	// =====================================================
	// Checks
	// target range check
	a_a11_range: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_A11)) |->
		(addrRes.addr >= `OAD_A11_LO && addrRes.addr <= `OAD_A11_HI))
		else $error("eleven-bit target out of range");
	a_a5_even: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_A5)) |->
		(!addrRes.addr[0] && addrRes.addr >= `OAD_A5_LO && addrRes.addr <= `OAD_A5_HI))
		else $error("table target illegal");
	a_saddr_window: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_SADDR)) |->
		(addrRes.addr >= `OAD_SADDR_LO && addrRes.addr <= `OAD_SADDR_HI))
		else $error("short direct outside window");
	a_sfr_hole: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_SFR) && addrRes.addr >= `OAD_SFR_HOLE_LO &&
		addrRes.addr <= `OAD_SFR_HOLE_HI) |-> !addrRes.legal)
		else $error("sfr hole accepted");
	a_bank_next: assert property (@(posedge mclk) disable iff (!arst_n)
		exec_r && !(wrFire && wrPsw) |=> bank_r == {$past(psw_r[5]), $past(psw_r[3])})
		else $error("bank not taken from flag");
	a_flag_set: assert property (@(posedge mclk) disable iff (!arst_n)
		exec_r && actCy == 3'(oad_pkg::OAD_F_SET) |=> psw_r[0])
		else $error("carry not set");
	a_abs16_odd: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_ABS16) && immWord[0]) |-> !addrRes.legal)
		else $error("odd word address accepted");
	a_rel_sign: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_REL) && immByte[7]) |-> addrRes.addr < pairVal ||
		pairVal < 16'h0080)
		else $error("displacement not signed");
	a_saddrp_odd: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_SADDRP) && addrRes.addr[0]) |-> !addrRes.legal)
		else $error("odd short direct word accepted");
	a_sfrp_odd: assert property (@(posedge mclk) disable iff (!arst_n)
		(ctrl_r[3:0] == 4'(oad_pkg::OAD_SFRP) && immWord[0]) |-> !addrRes.legal)
		else $error("odd word sfr accepted");
	a_flag_clr: assert property (@(posedge mclk) disable iff (!arst_n)
		exec_r && actCy == 3'(oad_pkg::OAD_F_CLR) |=> !psw_r[0])
		else $error("carry not cleared");
	a_flag_keep: assert property (@(posedge mclk) disable iff (!arst_n)
		exec_r && actCy == 3'(oad_pkg::OAD_F_KEEP) |=> psw_r[0] == $past(psw_r[0]))
		else $error("carry changed under keep");
	a_bank_hold: assert property (@(posedge mclk) disable iff (!arst_n)
		!exec_r |=> bank_r == $past(bank_r))
		else $error("bank changed without execute");
endmodule : operand_addressing_decoder
`default_nettype wire

// file: oad_defines.svh
`ifndef OAD_DEFINES_SVH
`define OAD_DEFINES_SVH
// =====================================================
// Register offsets (byte addresses, AXI4-Lite)
`define OAD_OFF_CTRL 12'h000
`define OAD_OFF_OPER 12'h004
`define OAD_OFF_STAT 12'h008
`define OAD_OFF_RESULT 12'h00C
`define OAD_OFF_PSW 12'h010
`define OAD_OFF_GREG 12'h014
// =====================================================
// Address windows
`define OAD_SADDR_LO 16'hFE20
`define OAD_SADDR_HI 16'hFF1F
`define OAD_SFR_LO 16'hFF00
`define OAD_SFR_HOLE_LO 16'hFFD0
`define OAD_SFR_HOLE_HI 16'hFFDF
`define OAD_A11_LO 16'h0800
`define OAD_A11_HI 16'h0FFF
`define OAD_A5_LO 16'h0040
`define OAD_A5_HI 16'h007F
// =====================================================
// Flag positions in the status word
`define OAD_CY_BIT 0
`define OAD_BANK_LO 3
`define OAD_AC_BIT 4
`define OAD_BANK_HI 5
`define OAD_Z_BIT 6
`define OAD_IE_BIT 7
`define OAD_PSW_RST 8'h02
`endif

// file: oad_pkg.sv
`default_nettype none
package oad_pkg;
	// Addressing forms of an operand
	typedef enum logic [3:0] {
		OAD_SADDR, OAD_SADDRP, OAD_SFR, OAD_SFRP, OAD_ABS8, OAD_ABS16,
		OAD_A11, OAD_A5, OAD_REL
	} oad_mode_e;
	// Per-flag action code
	typedef enum logic [2:0] {
		OAD_F_KEEP, OAD_F_CLR, OAD_F_SET, OAD_F_RES, OAD_F_RESTORE
	} oad_fact_e;
	// Decoded address result
	typedef struct packed {
		logic legal;
		logic [15:0] addr;
	} oad_addr_s;
endpackage : oad_pkg
`default_nettype wire

// file: oad_flag_unit.sv
`default_nettype none
// =====================================================
// One status flag update, instanced per flag
module oad_flag_unit (
	// Action and sources
	input wire logic [2:0] act,
	input wire logic cur,
	input wire logic res,
	input wire logic saved,
	// Next value
	output logic nxt
);
	always_comb
	begin
		unique case (oad_pkg::oad_fact_e'(act))
			oad_pkg::OAD_F_CLR: nxt = 1'b0;
			oad_pkg::OAD_F_SET: nxt = 1'b1;
			oad_pkg::OAD_F_RES: nxt = res;
			oad_pkg::OAD_F_RESTORE: nxt = saved;
			default: nxt = cur;
		endcase
	end
endmodule : oad_flag_unit
`default_nettype wire

// file: oad_addr_check.sv
`default_nettype none
`include "oad_defines.svh"
// =====================================================
// Address operand resolver and legality check
module oad_addr_check (
	// Operand
	input wire logic [3:0] mode,
	input wire logic [15:0] opnd,
	input wire logic [15:0] pc,
	input wire logic sfr16Ok,
	// Result
	output var oad_pkg::oad_addr_s res
);
	// Short direct wraps into its window from its low byte
	wire logic [15:0] saddrA = (opnd[7:0] >= 8'h20) ? {8'hFE, opnd[7:0]} : {8'hFF, opnd[7:0]};
	wire logic [15:0] sfrA = {8'hFF, opnd[7:0]};
	wire logic [15:0] a11A = {5'b00001, opnd[10:0]};
	wire logic [15:0] a5A = {9'h000, 1'b1, opnd[4:0], 1'b0};
	// Target wraps round the 64K space, carry out dropped on purpose
	wire logic [15:0] relA = 16'(pc + {{8{opnd[7]}}, opnd[7:0]});
	wire logic inHole = (sfrA >= `OAD_SFR_HOLE_LO) && (sfrA <= `OAD_SFR_HOLE_HI);
	always_comb
	begin
		res = '{legal: 1'b1, addr: opnd};
		unique case (oad_pkg::oad_mode_e'(mode))
			oad_pkg::OAD_SADDR: res = '{legal: 1'b1, addr: saddrA};
			oad_pkg::OAD_SADDRP: res = '{legal: ~saddrA[0], addr: saddrA};
			oad_pkg::OAD_SFR: res = '{legal: ~inHole, addr: sfrA};
			oad_pkg::OAD_SFRP: res = '{legal: ~inHole & sfr16Ok & ~sfrA[0], addr: sfrA};
			oad_pkg::OAD_ABS8: res = '{legal: 1'b1, addr: opnd};
			oad_pkg::OAD_ABS16: res = '{legal: ~opnd[0], addr: opnd};
			oad_pkg::OAD_A11: res = '{legal: 1'b1, addr: a11A};
			oad_pkg::OAD_A5: res = '{legal: 1'b1, addr: a5A};
			oad_pkg::OAD_REL: res = '{legal: 1'b1, addr: relA};
			default: res = '{legal: 1'b0, addr: 16'h0000};
		endcase
	end
endmodule : oad_addr_check
`default_nettype wire

// file: oad_fetch_model.sv
`default_nettype none
// =====================================================
// Fetch path model: hands operand words in over AXI4-Lite
module oad_fetch_model (
	// Clock
	input wire logic mclk,
	// Write address and data
	output logic [11:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	// Write response
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read address and data
	output logic [11:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// Notes: expected write code, and {code, mask, word} per read
	logic [1:0] wrQ[$];
	logic [65:0] rdQ[$];

	// Idle bus at time zero
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end

	// One write; each channel dropped only at its own taking edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic done;
		done = 1'b0;
		wrQ.push_back(r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done)
		begin
			@(posedge mclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			done = s_axi_bvalid;
		end
		s_axi_bready <= 1'b0;
	endtask : wr

	// One read; ready held until the answer is sampled
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] r);
		rdQ.push_back({r, m, e});
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
endmodule : oad_fetch_model
`default_nettype wire

// file: test_operand_addressing_decoder.sv
`default_nettype none
`include "oad_defines.svh"
// =====================================================
// Self-checking bench for the operand decoder
module test_operand_addressing_decoder;
	timeunit 1ns;
	timeprecision 100ps;
	// Clock, reset and bus
	logic mclk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	// Counters, random register bytes, flag cases
	int numErrors = 0;
	int totalChecks = 0;
	integer seed = 12;
	logic [7:0] vals[8];
	logic [65:0] note;
	logic [2:0] acts[5] = '{3'h2, 3'h1, 3'h0, 3'h4, 3'h3};
	logic cyExp[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

	operand_addressing_decoder DUT (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	oad_fetch_model fetch (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
		.s_axi_rready);

	// =====================================================
	// Clock and watchdog
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		numErrors++;
		endSim();
	end

	// =====================================================
	// Comparison and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp)
		begin
			numErrors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic endSim;
		$display("Checks %0d, errors %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : endSim

	// Each answer taken against the oldest note
	always @(posedge mclk)
	begin
		if (s_axi_bvalid && s_axi_bready)
			check({30'h0, s_axi_bresp}, {30'h0, fetch.wrQ.pop_front()});
		if (s_axi_rvalid && s_axi_rready)
		begin
			note = fetch.rdQ.pop_front();
			check({30'h0, s_axi_rresp}, {30'h0, note[65:64]});
			check(s_axi_rdata & note[63:32], note[31:0] & note[63:32]);
		end
	end

	// Resolve one operand; address bits only kept when legal
	task automatic at(input logic [3:0] md, input logic s16, input logic [15:0] op,
		input logic ok, input logic [15:0] ad);
		fetch.wr(`OAD_OFF_OPER, {16'h0000, op}, 2'b00);
		fetch.wr(`OAD_OFF_CTRL, {26'h000_0000, 1'b1, s16, md}, 2'b00);
		fetch.rd(`OAD_OFF_RESULT, ok ? 32'h01FF_FFFF : 32'h01FF_0000,
			{7'h00, ok, vals[1], ad}, 2'b00);
	endtask : at

	// =====================================================
	// Main sequence
	initial
	begin
		arst_n = 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		// Reset state, then an unmapped place that must change nothing
		fetch.rd(`OAD_OFF_STAT, 32'h0000_03FF, 32'h0000_0002, 2'b00);
		fetch.rd(12'h018, 32'h0000_0000, 32'h0000_0000, 2'b10);
		fetch.wr(12'h018, 32'hFFFF_FFFF, 2'b10);
		fetch.rd(`OAD_OFF_PSW, 32'h0000_00FF, 32'h0000_0002, 2'b00);
		for (int i = 0; i < 8; i++)
		begin
			vals[i] = 8'($random(seed));
			fetch.wr(`OAD_OFF_CTRL, {23'h00_0000, i[2:0], 6'h00}, 2'b00);
			fetch.wr(`OAD_OFF_GREG, {24'h00_0000, vals[i]}, 2'b00);
		end
		for (int i = 0; i < 8; i++)
		begin
			fetch.wr(`OAD_OFF_CTRL, {23'h00_0000, i[2:0], 6'h20}, 2'b00);
			fetch.rd(`OAD_OFF_GREG, 32'h0000_00FF, {24'h00_0000, vals[i]}, 2'b00);
		end
		// pairs built from two byte halves
		for (int p = 0; p < 4; p++)
		begin
			fetch.wr(`OAD_OFF_CTRL, {22'h00_0000, 2'b10, p[1:0], 6'h20}, 2'b00);
			fetch.rd(`OAD_OFF_GREG, 32'h0000_FFFF,
				{16'h0000, vals[2 * p + 1], vals[2 * p]}, 2'b00);
		end
		// window edges and odd word addresses
		at(4'h0, 1'b0, 16'h0020, 1'b1, 16'hFE20);
		at(4'h0, 1'b0, 16'h001F, 1'b1, 16'hFF1F);
		at(4'h1, 1'b0, 16'h0021, 1'b0, 16'h0000);
		at(4'h1, 1'b0, 16'h0022, 1'b1, 16'hFE22);
		at(4'h2, 1'b0, 16'h00CF, 1'b1, 16'hFFCF);
		at(4'h2, 1'b0, 16'h00D0, 1'b0, 16'h0000);
		at(4'h2, 1'b0, 16'h00DF, 1'b0, 16'h0000);
		at(4'h2, 1'b0, 16'h00E0, 1'b1, 16'hFFE0);
		at(4'h3, 1'b1, 16'h0010, 1'b1, 16'hFF10);
		at(4'h3, 1'b1, 16'h0011, 1'b0, 16'h0000);
		at(4'h3, 1'b0, 16'h0010, 1'b0, 16'h0000);
		at(4'h4, 1'b0, 16'hFFFF, 1'b1, 16'hFFFF);
		at(4'h5, 1'b0, 16'hFFFF, 1'b0, 16'h0000);
		at(4'h5, 1'b0, 16'hFFFE, 1'b1, 16'hFFFE);
		at(4'h6, 1'b0, 16'h07FF, 1'b1, 16'h0FFF);
		at(4'h7, 1'b0, 16'h0000, 1'b1, 16'h0040);
		at(4'h8, 1'b0, 16'h0080, 1'b1, {vals[1], vals[0]} + 16'hFF80);
		at(4'h8, 1'b0, 16'h007F, 1'b1, {vals[1], vals[0]} + 16'h007F);
		// bank switch seen only after an execute
		fetch.wr(`OAD_OFF_PSW, 32'h0000_0028, 2'b00);
		fetch.rd(`OAD_OFF_STAT, 32'h0000_03FF, 32'h0000_0028, 2'b00);
		fetch.wr(`OAD_OFF_CTRL, 32'h0000_0060, 2'b00);
		fetch.rd(`OAD_OFF_STAT, 32'h0000_03FF, 32'h0000_0328, 2'b00);
		fetch.wr(`OAD_OFF_GREG, {24'h00_0000, ~vals[1]}, 2'b00);
		fetch.wr(`OAD_OFF_CTRL, 32'h0000_0060, 2'b00);
		fetch.rd(`OAD_OFF_GREG, 32'h0000_00FF, {24'h00_0000, ~vals[1]}, 2'b00);
		fetch.wr(`OAD_OFF_PSW, 32'h0000_0002, 2'b00);
		fetch.wr(`OAD_OFF_CTRL, 32'h0000_0060, 2'b00);
		fetch.rd(`OAD_OFF_GREG, 32'h0000_00FF, {24'h00_0000, vals[1]}, 2'b00);
		// carry under set, clear, keep, restore
		fetch.wr(`OAD_OFF_PSW, 32'h0000_0001, 2'b00);
		fetch.wr(`OAD_OFF_PSW, 32'h0000_0002, 2'b00);
		// Result action tests bit 4 of byte 04h, which is clear
		for (int k = 0; k < 5; k++)
		begin
			fetch.wr(`OAD_OFF_OPER, {13'h0000, acts[k], 16'h0004}, 2'b00);
			fetch.wr(`OAD_OFF_CTRL, 32'h0000_0020, 2'b00);
			fetch.rd(`OAD_OFF_STAT, 32'h0000_00FF, {24'h00_0000, 7'h01, cyExp[k]}, 2'b00);
		end
		repeat (4) @(posedge mclk);
		endSim();
	end
endmodule : test_operand_addressing_decoder
`default_nettype wire
